/* hw/dsw_ctrl.sv */
// Purpose: Control logic of a dual high-side switch: modes, watchdog, SPI slave, faults, PWM.
// Assumes: All pins except the fault, window and supply inputs come from outside the MCLK domain.
// Notes: Fault, window and supply inputs are taken as already synchronous to MCLK.
`default_nettype none

// Function
// - Normal mode: channel with PWM disabled follows its direct input, low off, high on.
// - In sleep, a rising edge on either direct input wakes the device.
// - Load select low picks bulb profile, high picks motor; open pin reads high.
// - Open-drain fault flag pulled low while any listed fault is present.
// - Each fault sets its own status bit; reading that register clears it.
// - Loss of the external PWM clock raises a clock-fail fault while a channel has PWM enabled.
// - Internal PWM sets on-time and turn-on delay of PWM channels.
// - All SPI registers stay at reset value while reset pin is low.
// - Reset low: sleep a filter delay after last direct input falls.
// - Stay asleep while reset pin and both direct inputs are low.
// - Rising reset pin wakes device and starts the SPI watchdog.
// - Watchdog checks the first bit of every SPI word, any register.
// - Toggle bit unchanged within timeout: enter fail-safe; master must alternate it.
// - SPI shifting accepted only while chip select is low.
// - Chip select rising copies input shift word into addressed register.
// - Chip select falling loads output shift register from one of eight registers.
// - Serial output driven only while chip select low, else high impedance.
// - Sense-ready pulled low when sense valid, released at channel turn-off.
// - Current-sense output tri-stated when both sense select bits are clear.
// - Sense output off during overcurrent window, fail-safe, or missing logic supply.
// - Track-and-hold keeps presenting the pre-turn-off current during switch-off.
// - Frames are 16 bits, MSB first, address in bits 12 to 9.
// - Serial input sampled on falling serial clock edges.
// - Serial output updated on rising serial clock edges.
// - Serial clock and input ignored while chip select is high.
module dsw_ctrl #(
	parameter int IN_FILTER_CYC = dsw_pkg::IN_FILTER_CYC,
	parameter int WD_TIMEOUT_CYC = dsw_pkg::WD_TIMEOUT_CYC
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic RESET_N_WAKE,
	input wire logic [1:0] DIRECT_IN,
	input wire logic [1:0] LOAD_PROFILE_SEL,
	input wire logic PWM_CLOCK,
	input wire logic SCLK,
	input wire logic SI,
	input wire logic CHIP_SELECT_N,
	input wire logic [1:0] OVERCURRENT_FAULT,
	input wire logic [1:0] OVERTEMP_FAULT,
	input wire logic [1:0] SUPPLY_SHORT_FAULT,
	input wire logic [1:0] SEVERE_SHORT_FAULT,
	input wire logic [1:0] OPEN_LOAD_ON,
	input wire logic [1:0] OPEN_LOAD_OFF,
	input wire logic OVERVOLTAGE_FAULT,
	input wire logic UNDERVOLTAGE_FAULT,
	input wire logic VDD_OK,
	input wire logic [1:0] OC_WINDOW,
	output logic [1:0] CH_ON,
	output logic [1:0] PROFILE_MOTOR,
	output logic [1:0] MODE,
	output logic SO_O,
	output logic SO_OE,
	output logic FAULT_FLAG_N_O,
	output logic FAULT_FLAG_N_OE,
	output logic SENSE_READY_N_O,
	output logic SENSE_READY_N_OE,
	output logic CURRENT_SENSE_OE,
	output logic [1:0] CURRENT_SENSE_SEL,
	output logic SENSE_HOLD
);

	// ----------------------------------------------------------------
	// Types and helpers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rs1, rs2, rst_d;
		logic [1:0] in_s1, in_s2, in_d;
		logic cs_s1, cs_s2, cs_d;
		logic sck_s1, sck_s2, sck_d;
		logic si_s1, si_s2;
		logic pck_s1, pck_s2, pck_d;
		logic [1:0] prof_s1, prof_s2;
		dsw_pkg::dsw_mode_t mode;
		logic [12:0] filt_cnt;
		logic [14:0] wd_cnt;
		logic wd_last, wd_any;
		logic [8:0] gcfg, ch0cfg, ch1cfg;
		logic [8:0] gstat, fault0, fault1, diag0, diag1;
		logic [2:0] rd_sel;
		logic [15:0] si_shift, so_shift;
		logic [4:0] bit_cnt;
		logic so_en;
		logic [9:0] clk_cnt;
		logic [3:0] phase;
		logic [1:0] ch_on;
		logic [9:0] sense_cnt;
		logic sync_low, hold_valid, hold, fflag;
	} dsw_state_t;

	function automatic logic [8:0] sticky(input logic [8:0] old, input logic [8:0] set,
		input logic clr);
		sticky = set | (clr ? 9'h000 : old);
	endfunction

	function automatic logic pwm_on(input logic [3:0] phase, input logic [8:0] cfg);
		logic [3:0] duty;
		logic [3:0] dly;
		logic [3:0] rel;
		duty = cfg[dsw_pkg::CH_DUTY_LSB +: 4];
		dly = cfg[dsw_pkg::CH_DELAY_LSB +: 4];
		rel = phase - dly;
		pwm_on = (phase >= dly) && (rel < duty);
	endfunction

	logic rst_m, rst_n;
	dsw_state_t st, next_st;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic cs_fall, cs_rise, sck_rise, sck_fall, pck_edge, rst_rise, in_rise, any_fault;
	logic [8:0] live_g, live_f0, live_f1, live_d0, live_d1, rd_data;
	logic [1:0] pwm_q, sel_on;
	logic [3:0] waddr;

	always_comb
	begin
		next_st = st;
		next_st.rs1 = RESET_N_WAKE;
		next_st.rs2 = st.rs1;
		next_st.rst_d = st.rs2;
		next_st.in_s1 = DIRECT_IN;
		next_st.in_s2 = st.in_s1;
		next_st.in_d = st.in_s2;
		next_st.cs_s1 = CHIP_SELECT_N;
		next_st.cs_s2 = st.cs_s1;
		next_st.cs_d = st.cs_s2;
		next_st.sck_s1 = SCLK;
		next_st.sck_s2 = st.sck_s1;
		next_st.sck_d = st.sck_s2;
		next_st.si_s1 = SI;
		next_st.si_s2 = st.si_s1;
		next_st.pck_s1 = PWM_CLOCK;
		next_st.pck_s2 = st.pck_s1;
		next_st.pck_d = st.pck_s2;
		next_st.prof_s1 = LOAD_PROFILE_SEL;
		next_st.prof_s2 = st.prof_s1;

		cs_fall = st.cs_d & ~st.cs_s2;
		cs_rise = ~st.cs_d & st.cs_s2;
		sck_rise = ~st.cs_s2 & ~st.sck_d & st.sck_s2;
		sck_fall = ~st.cs_s2 & st.sck_d & ~st.sck_s2;
		pck_edge = st.pck_d ^ st.pck_s2;
		rst_rise = st.rs2 & ~st.rst_d;
		in_rise = |(st.in_s2 & ~st.in_d);
		waddr = st.si_shift[dsw_pkg::ADDR_MSB:dsw_pkg::ADDR_LSB];

		// A dead PWM clock only matters while a channel depends on it.
		next_st.clk_cnt = pck_edge ? 10'h000 :
			(st.clk_cnt == 10'(dsw_pkg::CLKMON_CYC) ? st.clk_cnt : st.clk_cnt + 10'h001);
		next_st.phase = (pck_edge && st.pck_s2) ? st.phase + 4'h1 : st.phase;

		// Live fault vectors, one bit per fault type.
		live_g = '0;
		live_g[dsw_pkg::GST_CLKFAIL] = (st.clk_cnt == 10'(dsw_pkg::CLKMON_CYC)) &&
			(st.ch0cfg[dsw_pkg::CH_PWM_EN] || st.ch1cfg[dsw_pkg::CH_PWM_EN]);
		live_g[dsw_pkg::GST_OV] = OVERVOLTAGE_FAULT;
		live_g[dsw_pkg::GST_UV] = UNDERVOLTAGE_FAULT;
		live_f0 = {5'h00, SEVERE_SHORT_FAULT[0], SUPPLY_SHORT_FAULT[0], OVERTEMP_FAULT[0],
			OVERCURRENT_FAULT[0]};
		live_f1 = {5'h00, SEVERE_SHORT_FAULT[1], SUPPLY_SHORT_FAULT[1], OVERTEMP_FAULT[1],
			OVERCURRENT_FAULT[1]};
		live_d0 = {7'h00, OPEN_LOAD_OFF[0], OPEN_LOAD_ON[0]};
		live_d1 = {7'h00, OPEN_LOAD_OFF[1], OPEN_LOAD_ON[1]};
		any_fault = |{live_g, live_f0, live_f1, live_d0, live_d1};
		next_st.fflag = any_fault;

		// Operating mode.
		if (st.mode != dsw_pkg::MODE_SLEEP && !st.rs2 && st.in_s2 == 2'b00)
			next_st.filt_cnt = st.filt_cnt + 13'h0001;
		else
			next_st.filt_cnt = '0;
		case (st.mode)
			dsw_pkg::MODE_SLEEP:
			begin
				if (rst_rise || in_rise)
					next_st.mode = dsw_pkg::MODE_NORMAL;
			end
			dsw_pkg::MODE_NORMAL:
			begin
				if (st.filt_cnt == 13'(IN_FILTER_CYC - 1))
					next_st.mode = dsw_pkg::MODE_SLEEP;
				else if (st.rs2 && st.wd_cnt == 15'(WD_TIMEOUT_CYC - 1))
					next_st.mode = dsw_pkg::MODE_FAILSAFE;
			end
			dsw_pkg::MODE_FAILSAFE:
			begin
				if (st.filt_cnt == 13'(IN_FILTER_CYC - 1))
					next_st.mode = dsw_pkg::MODE_SLEEP;
				else if (rst_rise)
					next_st.mode = dsw_pkg::MODE_NORMAL;
			end
			default:
			begin
				next_st.mode = dsw_pkg::MODE_SLEEP;
			end
		endcase

		// Read mux over the eight readable registers.
		if (st.rd_sel == 3'(dsw_pkg::ADDR_GCFG))
			rd_data = st.gcfg;
		else if (st.rd_sel == 3'(dsw_pkg::ADDR_CH0CFG))
			rd_data = st.ch0cfg;
		else if (st.rd_sel == 3'(dsw_pkg::ADDR_CH1CFG))
			rd_data = st.ch1cfg;
		else if (st.rd_sel == dsw_pkg::RD_GSTAT)
			rd_data = st.gstat;
		else if (st.rd_sel == dsw_pkg::RD_FAULT0)
			rd_data = st.fault0;
		else if (st.rd_sel == dsw_pkg::RD_FAULT1)
			rd_data = st.fault1;
		else if (st.rd_sel == dsw_pkg::RD_DIAG0)
			rd_data = st.diag0;
		else
			rd_data = st.diag1;

		// SPI shifting.
		next_st.so_en = ~st.cs_s2 && st.mode != dsw_pkg::MODE_SLEEP && VDD_OK;
		if (cs_fall)
		begin
			next_st.so_shift = {4'h0, st.rd_sel, rd_data};
			next_st.bit_cnt = '0;
		end
		else
		begin
			if (sck_fall)
			begin
				next_st.si_shift = {st.si_shift[14:0], st.si_s2};
				next_st.bit_cnt = (st.bit_cnt == 5'h1f) ? st.bit_cnt : st.bit_cnt + 5'h01;
			end
			// The first rising edge precedes any sample, so the MSB must stay put.
			if (sck_rise && st.bit_cnt != 5'h00)
				next_st.so_shift = {st.so_shift[14:0], 1'b0};
		end

		// Watchdog runs only in normal mode and while the reset pin is high.
		if (rst_rise || st.mode != dsw_pkg::MODE_NORMAL || !st.rs2)
		begin
			next_st.wd_cnt = '0;
			if (rst_rise)
				next_st.wd_any = 1'b0;
		end
		else if (st.wd_cnt != 15'(WD_TIMEOUT_CYC - 1))
			next_st.wd_cnt = st.wd_cnt + 15'h0001;

		if (cs_rise && st.bit_cnt == 5'(dsw_pkg::WORD_BITS))
		begin
			next_st.rd_sel = waddr[2:0];
			if (!st.wd_any || st.si_shift[dsw_pkg::WD_BIT] != st.wd_last)
			begin
				next_st.wd_cnt = '0;
				next_st.wd_any = 1'b1;
			end
			next_st.wd_last = st.si_shift[dsw_pkg::WD_BIT];
			if (waddr == dsw_pkg::ADDR_GCFG)
				next_st.gcfg = st.si_shift[dsw_pkg::DATA_BITS-1:0];
			else if (waddr == dsw_pkg::ADDR_CH0CFG)
				next_st.ch0cfg = st.si_shift[dsw_pkg::DATA_BITS-1:0];
			else if (waddr == dsw_pkg::ADDR_CH1CFG)
				next_st.ch1cfg = st.si_shift[dsw_pkg::DATA_BITS-1:0];
		end

		// Status bits: hardware set beats a read clear in the same cycle.
		next_st.gstat = sticky(st.gstat, live_g, cs_fall && st.rd_sel == dsw_pkg::RD_GSTAT);
		next_st.gstat[dsw_pkg::GST_FAILSAFE] = (st.mode == dsw_pkg::MODE_FAILSAFE);
		next_st.gstat[dsw_pkg::GST_CH0_ON] = st.ch_on[0];
		next_st.gstat[dsw_pkg::GST_CH1_ON] = st.ch_on[1];
		next_st.fault0 = sticky(st.fault0, live_f0, cs_fall && st.rd_sel == dsw_pkg::RD_FAULT0);
		next_st.fault1 = sticky(st.fault1, live_f1, cs_fall && st.rd_sel == dsw_pkg::RD_FAULT1);
		next_st.diag0 = sticky(st.diag0, live_d0, cs_fall && st.rd_sel == dsw_pkg::RD_DIAG0);
		next_st.diag1 = sticky(st.diag1, live_d1, cs_fall && st.rd_sel == dsw_pkg::RD_DIAG1);

		// The register file is frozen at reset while the reset pin is low.
		if (!st.rs2 || st.mode == dsw_pkg::MODE_SLEEP)
		begin
			next_st.gcfg = dsw_pkg::GCFG_RESET;
			next_st.ch0cfg = dsw_pkg::CHCFG_RESET;
			next_st.ch1cfg = dsw_pkg::CHCFG_RESET;
			next_st.gstat = '0;
			next_st.fault0 = '0;
			next_st.fault1 = '0;
			next_st.diag0 = '0;
			next_st.diag1 = '0;
			next_st.rd_sel = '0;
		end

		// Channel drive.
		pwm_q[0] = st.ch0cfg[dsw_pkg::CH_PWM_EN] ? pwm_on(st.phase, st.ch0cfg) : st.in_s2[0];
		pwm_q[1] = st.ch1cfg[dsw_pkg::CH_PWM_EN] ? pwm_on(st.phase, st.ch1cfg) : st.in_s2[1];
		if (st.mode == dsw_pkg::MODE_NORMAL)
			next_st.ch_on = pwm_q;
		else if (st.mode == dsw_pkg::MODE_FAILSAFE)
			next_st.ch_on = st.in_s2;
		else
			next_st.ch_on = 2'b00;

		// Sense readiness follows the selected channel.
		sel_on[0] = st.gcfg[dsw_pkg::GCFG_SENSE0] && !st.gcfg[dsw_pkg::GCFG_SENSE1] && st.ch_on[0];
		sel_on[1] = st.gcfg[dsw_pkg::GCFG_SENSE1] && !st.gcfg[dsw_pkg::GCFG_SENSE0] && st.ch_on[1];
		if (sel_on == 2'b00)
		begin
			next_st.sense_cnt = '0;
			next_st.sync_low = 1'b0;
		end
		else if (st.sense_cnt == 10'(dsw_pkg::SENSE_SETTLE_CYC))
			next_st.sync_low = 1'b1;
		else
			next_st.sense_cnt = st.sense_cnt + 10'h001;
		if (st.sync_low)
			next_st.hold_valid = 1'b1;
		else if (sel_on != 2'b00 || st.gcfg[1:0] == 2'b00)
			next_st.hold_valid = 1'b0;
		next_st.hold = st.gcfg[dsw_pkg::GCFG_TRACK] && st.hold_valid && !st.sync_low;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.cs_s1 <= 1'b1;
			st.cs_s2 <= 1'b1;
			st.cs_d <= 1'b1;
			st.prof_s1 <= 2'b11;
			st.prof_s2 <= 2'b11;
			st.mode <= dsw_pkg::MODE_SLEEP;
		end
		else
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign CH_ON = st.ch_on;
	assign PROFILE_MOTOR = st.prof_s2;
	assign MODE = st.mode;
	assign SO_O = st.so_shift[15];
	assign SO_OE = st.so_en;
	assign FAULT_FLAG_N_O = 1'b0;
	assign FAULT_FLAG_N_OE = st.fflag;
	assign SENSE_READY_N_O = 1'b0;
	assign SENSE_READY_N_OE = st.sync_low;
	assign CURRENT_SENSE_SEL = st.gcfg[1:0];
	assign CURRENT_SENSE_OE = (st.gcfg[1:0] != 2'b00) &&
		st.mode == dsw_pkg::MODE_NORMAL && VDD_OK && (OC_WINDOW == 2'b00);
	assign SENSE_HOLD = st.hold;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!rst_n);

	sequence s_cs_high;
		st.cs_s2 && st.cs_d;
	endsequence
	sequence s_word_done;
		cs_rise && st.bit_cnt == 5'(dsw_pkg::WORD_BITS) && st.rs2 && st.mode != dsw_pkg::MODE_SLEEP;
	endsequence

	property p_direct;
		st.mode == dsw_pkg::MODE_NORMAL && !st.ch0cfg[dsw_pkg::CH_PWM_EN] ##0 st.mode ==
			dsw_pkg::MODE_NORMAL |=> CH_ON[0] == $past(st.in_s2[0]);
	endproperty
	a_direct: assert property (p_direct) else $error("channel 0 ignores direct input");

	property p_wake;
		st.mode == dsw_pkg::MODE_SLEEP && in_rise |=> st.mode == dsw_pkg::MODE_NORMAL;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on direct input");

	property p_fault_flag;
		any_fault |=> FAULT_FLAG_N_OE && !FAULT_FLAG_N_O;
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("fault flag not pulled");

	property p_regs_reset;
		!st.rs2 |=> st.gcfg == dsw_pkg::GCFG_RESET && st.ch0cfg == dsw_pkg::CHCFG_RESET &&
			st.fault0 == 9'h000;
	endproperty
	a_regs_reset: assert property (p_regs_reset) else $error("register not held at reset");

	property p_sleep_entry;
		st.mode == dsw_pkg::MODE_NORMAL && !st.rs2 && st.in_s2 == 2'b00 &&
			st.filt_cnt == 13'(IN_FILTER_CYC - 1) |=> st.mode == dsw_pkg::MODE_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

	property p_stay_sleep;
		st.mode == dsw_pkg::MODE_SLEEP && !st.rs2 && st.in_s2 == 2'b00 &&
			st.in_d == 2'b00 |=> st.mode == dsw_pkg::MODE_SLEEP;
	endproperty
	a_stay_sleep: assert property (p_stay_sleep) else $error("left sleep without cause");

	property p_wd_start;
		rst_rise |=> st.wd_cnt == 15'h0000 && st.mode != dsw_pkg::MODE_SLEEP;
	endproperty
	a_wd_start: assert property (p_wd_start) else $error("watchdog not started");

	property p_wd_fail;
		st.mode == dsw_pkg::MODE_NORMAL && st.rs2 && !rst_rise && st.filt_cnt == 13'h0000 &&
			st.wd_cnt == 15'(WD_TIMEOUT_CYC - 1) |=> st.mode == dsw_pkg::MODE_FAILSAFE;
	endproperty
	a_wd_fail: assert property (p_wd_fail) else $error("watchdog timeout missed");

	property p_commit;
		s_word_done ##0 (waddr == dsw_pkg::ADDR_GCFG) |=> st.gcfg == $past(st.si_shift[8:0]);
	endproperty
	a_commit: assert property (p_commit) else $error("word not committed");

	property p_so_off;
		s_cs_high |=> !SO_OE;
	endproperty
	a_so_off: assert property (p_so_off) else $error("serial output driven with select high");

	property p_sample;
		sck_fall && !cs_fall |=> st.si_shift[0] == $past(st.si_s2);
	endproperty
	a_sample: assert property (p_sample) else $error("serial input not sampled");

	property p_sense_tri;
		st.gcfg[1:0] == 2'b00 || st.mode == dsw_pkg::MODE_FAILSAFE |-> !CURRENT_SENSE_OE;
	endproperty
	a_sense_tri: assert property (p_sense_tri) else $error("sense output not tri-stated");

endmodule

`default_nettype wire

/* include/dsw_pkg.sv */
// Purpose: Shared constants and types of the dual switch control logic.
// Assumes: Core clock of 250 MHz; SPI words of 16 bits, most significant bit first.
// Notes: Timing figures are kept in ns; cycle counts are derived from them.
`default_nettype none

package dsw_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int IN_FILTER_NS = 20000;
	localparam int IN_FILTER_CYC = (IN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WD_TIMEOUT_NS = 100000;
	localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int CLKMON_NS = 2000;
	localparam int CLKMON_CYC = CLKMON_NS / CLK_PERIOD_NS;
	localparam int SENSE_SETTLE_NS = 1000;
	localparam int SENSE_SETTLE_CYC = (SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// SPI word layout
	// ----------------------------------------------------------------
	localparam int WORD_BITS = 16;
	localparam int WD_BIT = 15;
	localparam int ADDR_LSB = 9;
	localparam int ADDR_MSB = 12;
	localparam int DATA_BITS = 9;

	// ----------------------------------------------------------------
	// Register addresses (write) and read indices
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_GCFG = 4'h0;
	localparam logic [3:0] ADDR_CH0CFG = 4'h1;
	localparam logic [3:0] ADDR_CH1CFG = 4'h2;
	localparam logic [2:0] RD_GSTAT = 3'h3;
	localparam logic [2:0] RD_FAULT0 = 3'h4;
	localparam logic [2:0] RD_FAULT1 = 3'h5;
	localparam logic [2:0] RD_DIAG0 = 3'h6;
	localparam logic [2:0] RD_DIAG1 = 3'h7;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int GCFG_SENSE0 = 0;
	localparam int GCFG_SENSE1 = 1;
	localparam int GCFG_TRACK = 2;
	localparam int CH_PWM_EN = 0;
	localparam int CH_DUTY_LSB = 1;
	localparam int CH_DELAY_LSB = 5;
	localparam int GST_CLKFAIL = 0;
	localparam int GST_OV = 1;
	localparam int GST_UV = 2;
	localparam int GST_FAILSAFE = 3;
	localparam int GST_CH0_ON = 4;
	localparam int GST_CH1_ON = 5;
	localparam int FLT_OC = 0;
	localparam int FLT_OT = 1;
	localparam int FLT_SUPPLY = 2;
	localparam int FLT_SEVERE = 3;
	localparam int DG_OPEN_LOAD_ON = 0;
	localparam int DG_OPEN_LOAD_OFF = 1;
	localparam logic [8:0] GCFG_RESET = 9'h000;
	localparam logic [8:0] CHCFG_RESET = 9'h000;

	typedef enum logic [1:0] {
		MODE_SLEEP = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_FAILSAFE = 2'b10
	} dsw_mode_t;

endpackage

`default_nettype wire

/* verification/dsw_spi_master.sv */
// Purpose: SPI master partner that frames words on the serial link of the switch control.
// Assumes: MCLK at 250 MHz; SCLK period of 40 MCLK, that is 160 ns.
// Notes: Idle lines follow their pulls: SCLK and SI low, chip select high.
`default_nettype none

module dsw_spi_master (
	input wire logic MCLK,
	input wire logic SO_O,
	input wire logic SO_OE,
	output logic SCLK,
	output logic SI,
	output logic CHIP_SELECT_N
);
	timeunit 1ns;
	timeprecision 1ps;
	logic so_last = 1'b0;
	logic tog = 1'b0;
	// A released line shows a changing pattern so a stale value never reads as valid.
	wire logic so = SO_OE ? SO_O : ~so_last;

	initial
	begin
		SCLK = 1'b0;
		SI = 1'b0;
		CHIP_SELECT_N = 1'b1;
	end

	always @(posedge MCLK) so_last <= so;

	// ----------------------------------------------------------------
	// One whole word, most significant bit first
	// ----------------------------------------------------------------
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		int i;
		w[15] = tog;
		tog = ~tog;
		repeat (4) @(posedge MCLK);
		CHIP_SELECT_N <= 1'b0;
		repeat (130) @(posedge MCLK);
		for (i = 15; i >= 0; i--)
		begin
			SCLK <= 1'b1;
			SI <= w[i];
			repeat (20) @(posedge MCLK);
			SCLK <= 1'b0;
			r[i] = so;
			repeat (20) @(posedge MCLK);
		end
		CHIP_SELECT_N <= 1'b1;
		repeat (260) @(posedge MCLK);
		SI <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* verification/test_dsw_ctrl.sv */
// Purpose: Self-checking bench of the dual switch control logic.
// Assumes: Short filter and watchdog counts set as parameters.
// Notes: Fault inputs are driven as one vector, one source at a time.
`default_nettype none

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module test_dsw_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0, RST_B = 1'b0, RESET_N_WAKE = 1'b0, PWM_CLOCK = 1'b0, VDD_OK = 1'b1;
	logic [1:0] DIRECT_IN = 2'b00, LOAD_PROFILE_SEL = 2'b11, OC_WINDOW = 2'b00;
	logic [13:0] f = 14'h0;
	logic pck_run = 1'b1;
	wire logic SCLK, SI, CHIP_SELECT_N, SO_O, SO_OE, FAULT_FLAG_N_O, FAULT_FLAG_N_OE;
	wire logic SENSE_READY_N_O, SENSE_READY_N_OE, CURRENT_SENSE_OE, SENSE_HOLD;
	wire logic [1:0] CH_ON, PROFILE_MOTOR, MODE, CURRENT_SENSE_SEL;
	int num_errors = 0, tests_run = 0, cyc = 0, k, on_cnt;
	logic [15:0] r, d;

	always #2 MCLK = ~MCLK;
	// Holding pck_run low parks the PWM clock low so that the monitor sees it die.
	always #80 PWM_CLOCK = ~PWM_CLOCK & pck_run;

	dsw_ctrl #(.IN_FILTER_CYC(50), .WD_TIMEOUT_CYC(3000)) uut (.MCLK(MCLK), .RST_B(RST_B),
		.RESET_N_WAKE(RESET_N_WAKE), .DIRECT_IN(DIRECT_IN), .LOAD_PROFILE_SEL(LOAD_PROFILE_SEL),
		.PWM_CLOCK(PWM_CLOCK), .SCLK(SCLK), .SI(SI), .CHIP_SELECT_N(CHIP_SELECT_N),
		.OVERCURRENT_FAULT(f[1:0]), .OVERTEMP_FAULT(f[3:2]), .SUPPLY_SHORT_FAULT(f[5:4]),
		.SEVERE_SHORT_FAULT(f[7:6]), .OPEN_LOAD_ON(f[9:8]), .OPEN_LOAD_OFF(f[11:10]),
		.OVERVOLTAGE_FAULT(f[12]), .UNDERVOLTAGE_FAULT(f[13]), .VDD_OK(VDD_OK),
		.OC_WINDOW(OC_WINDOW), .CH_ON(CH_ON), .PROFILE_MOTOR(PROFILE_MOTOR), .MODE(MODE),
		.SO_O(SO_O), .SO_OE(SO_OE), .FAULT_FLAG_N_O(FAULT_FLAG_N_O),
		.FAULT_FLAG_N_OE(FAULT_FLAG_N_OE), .SENSE_READY_N_O(SENSE_READY_N_O),
		.SENSE_READY_N_OE(SENSE_READY_N_OE), .CURRENT_SENSE_OE(CURRENT_SENSE_OE),
		.CURRENT_SENSE_SEL(CURRENT_SENSE_SEL), .SENSE_HOLD(SENSE_HOLD));

	dsw_spi_master m (.MCLK(MCLK), .SO_O(SO_O), .SO_OE(SO_OE), .SCLK(SCLK), .SI(SI),
		.CHIP_SELECT_N(CHIP_SELECT_N));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] exp_rd(input logic [2:0] rs, input logic [8:0] v);
		return {4'h0, rs, v};
	endfunction

	function automatic logic [15:0] wr(input logic [3:0] a, input logic [8:0] v);
		return {3'h0, a, v};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
	endtask

	task automatic report_and_stop;
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// The ceiling leaves ample room over the roughly 12700 cycles of the sequence.
	always @(posedge MCLK)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h6108));
		tick(12);
		RST_B <= 1'b1;
		tick(6);
		`CHK(MODE, dsw_pkg::MODE_SLEEP)
		`CHK(CH_ON, 2'b00)
		DIRECT_IN <= 2'b01;
		tick(10);
		`CHK(MODE, dsw_pkg::MODE_NORMAL)
		for (k = 0; k < 8; k++)
		begin
			d = 16'($urandom);
			DIRECT_IN <= d[1:0];
			LOAD_PROFILE_SEL <= d[3:2];
			tick(8);
			`CHK(CH_ON, d[1:0])
			`CHK(PROFILE_MOTOR, d[3:2])
		end
		DIRECT_IN <= 2'b01;
		LOAD_PROFILE_SEL <= 2'b11;
		for (k = 0; k < 14; k++)
		begin
			f <= 14'h1 << k;
			tick(4);
			`CHK(FAULT_FLAG_N_OE, 1'b1)
			`CHK(FAULT_FLAG_N_O, 1'b0)
			f <= 14'h0;
			tick(4);
			`CHK(FAULT_FLAG_N_OE, 1'b0)
		end
		m.xfer(wr(dsw_pkg::ADDR_GCFG, 9'h003), r);
		`CHK(CURRENT_SENSE_SEL, 2'b00)
		`CHK(CURRENT_SENSE_OE, 1'b0)
		DIRECT_IN <= 2'b00;
		tick(20);
		`CHK(MODE, dsw_pkg::MODE_NORMAL)
		tick(70);
		`CHK(MODE, dsw_pkg::MODE_SLEEP)
		tick(200);
		`CHK(MODE, dsw_pkg::MODE_SLEEP)
		RESET_N_WAKE <= 1'b1;
		tick(10);
		`CHK(MODE, dsw_pkg::MODE_NORMAL)
		tick(1300);
		m.xfer(wr(dsw_pkg::ADDR_GCFG, 9'h005), r);
		`CHK(CURRENT_SENSE_SEL, 2'b01)
		`CHK(SO_OE, 1'b0)
		m.xfer(wr(4'h4, 9'h000), r);
		`CHK(r, exp_rd(3'h0, 9'h005))
		f <= 14'h4;
		tick(4);
		f <= 14'h0;
		m.xfer(wr(4'h4, 9'h000), r);
		`CHK(r, exp_rd(dsw_pkg::RD_FAULT0, 9'h002))
		m.xfer(wr(4'h4, 9'h000), r);
		`CHK(r, exp_rd(dsw_pkg::RD_FAULT0, 9'h000))
		`CHK(MODE, dsw_pkg::MODE_NORMAL)
		m.xfer(wr(dsw_pkg::ADDR_CH1CFG, 9'h049), r);
		on_cnt = 0;
		for (k = 0; k < 640; k++)
		begin
			tick(1);
			on_cnt += CH_ON[1];
		end
		// Duty of four phases, each one PWM clock period of forty core cycles.
		`CHK(on_cnt, 4 * 40)
		pck_run <= 1'b0;
		tick(600);
		`CHK(FAULT_FLAG_N_OE, 1'b1)
		pck_run <= 1'b1;
		tick(40);
		`CHK(FAULT_FLAG_N_OE, 1'b0)
		DIRECT_IN <= 2'b01;
		tick(270);
		`CHK(SENSE_READY_N_OE, 1'b1)
		`CHK(CURRENT_SENSE_OE, 1'b1)
		`CHK(SENSE_HOLD, 1'b0)
		OC_WINDOW <= 2'b01;
		tick(2);
		`CHK(CURRENT_SENSE_OE, 1'b0)
		OC_WINDOW <= 2'b00;
		VDD_OK <= 1'b0;
		tick(2);
		`CHK(CURRENT_SENSE_OE, 1'b0)
		VDD_OK <= 1'b1;
		DIRECT_IN <= 2'b00;
		tick(8);
		`CHK(SENSE_READY_N_OE, 1'b0)
		`CHK(SENSE_HOLD, 1'b1)
		tick(3100);
		`CHK(MODE, dsw_pkg::MODE_FAILSAFE)
		`CHK(CURRENT_SENSE_OE, 1'b0)
		report_and_stop();
	end
endmodule

`default_nettype wire
